// ---- hw/pin_cell.sv ----
// One shared pin: alternate or port drive, open-drain option
`timescale 1ns/10ps
`default_nettype none
module pin_cell (
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic alt_drive,
	input  wire logic alt_val,
	input  wire logic alt_float,
	input  wire logic port_dir,
	input  wire logic port_data,
	input  wire logic open_drain,
	output var  logic pad_out,
	output var  logic pad_oe
);
	logic drive;
	logic val;

	// ------------------------------------------------------------
	// Function select
	// ------------------------------------------------------------
	always_comb begin
		drive = port_dir;
		val   = port_data;
		if (alt_float) begin
			drive = 1'h0;
		end else if (alt_drive) begin
			drive = 1'h1;
			val   = alt_val;
		end
	end

	// Open drain only pulls low; a high is left to the board pull-up
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pad_out <= pin_mux_pkg::PAD_OUT_RST;
			pad_oe  <= pin_mux_pkg::PAD_OE_RST;
		end else if (open_drain) begin
			pad_out <= 1'h0;
			pad_oe  <= drive & ~val;
		end else begin
			pad_out <= val;
			pad_oe  <= drive;
		end
	end
endmodule // pin_cell
`default_nettype wire

// ---- hw/pin_input_gate.sv ----
// Gated sampling of pin levels toward the peripherals
`timescale 1ns/10ps
`default_nettype none
module pin_input_gate (
	input  wire logic                             mclk,
	input  wire logic                             rst_n,
	input  wire logic [pin_mux_pkg::IN_COUNT-1:0] raw,
	input  wire logic [pin_mux_pkg::IN_COUNT-1:0] enable,
	output var  logic [pin_mux_pkg::IN_COUNT-1:0] sampled
);
	// ------------------------------------------------------------
	// Disabled inputs present their idle level
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sampled <= pin_mux_pkg::IN_IDLE;
		end else begin
			sampled <= (raw & enable) | (pin_mux_pkg::IN_IDLE & ~enable);
		end
	end
endmodule // pin_input_gate
`default_nettype wire

// ---- hw/pin_mux_pkg.sv ----
// Package with constants for the shared pin function select block
// Contract
// - Upper address pins: port, or address 21-23
// - First upper pin outputs PWM channel five
// - Second upper pin feeds pulse generator trigger
// - Third upper pin outputs pulse generator waveform
// - One pin feeds A/D external trigger
// - Four pins carry serial memory interface
// - Two pins drive D/A outputs when enabled
// - Eight pins: port or analog input
// - Interrupt pins level sampled; pins 0-1 stay ports, 2-3 may carry compare
// - Six pins carry compare outputs when enabled
// - Four port pins feed capture edge inputs
// - Fourth capture pin may output prescaler clock
// - Serial-capable pins open-drain per setting bit
// - Three pins carry UART receive, transmit, clock
// - Extended serial group needs both selections
// - Bus clock pin: clock or port bit
// - Ready input in bus mode, else port
// - Hold handshake pins follow hold enable
// - Upper write strobe needs 16-bit bus mode
// - Lower write strobe in bus mode, enabled
// - Read strobe in bus mode, else port
package pin_mux_pkg;

	// ----------------------------------------------------------------
	// Pin groups and their base in the flattened pin vector
	// ----------------------------------------------------------------
	localparam int P4_WIDTH  = 3;
	localparam int P5_WIDTH  = 7;
	localparam int P6_WIDTH  = 8;
	localparam int P7_WIDTH  = 7;
	localparam int P8_WIDTH  = 8;
	localparam int P9_WIDTH  = 7;
	localparam int PA_WIDTH  = 6;
	localparam int P4_BASE   = 0;
	localparam int P5_BASE   = P4_BASE + P4_WIDTH;
	localparam int P6_BASE   = P5_BASE + P5_WIDTH;
	localparam int P7_BASE   = P6_BASE + P6_WIDTH;
	localparam int P8_BASE   = P7_BASE + P7_WIDTH;
	localparam int P9_BASE   = P8_BASE + P8_WIDTH;
	localparam int PA_BASE   = P9_BASE + P9_WIDTH;
	localparam int PIN_COUNT = PA_BASE + PA_WIDTH;

	// ----------------------------------------------------------------
	// Peripheral input slots in the sampled input vector
	// ----------------------------------------------------------------
	localparam int IN_TRIG  = 0;
	localparam int IN_ADC   = 1;
	localparam int IN_SMEM  = 2;
	localparam int IN_IRQ   = 3;
	localparam int IN_CAP   = 7;
	localparam int IN_URX   = 11;
	localparam int IN_ERX   = 12;
	localparam int IN_RDY   = 13;
	localparam int IN_HRQ   = 14;
	localparam int IN_COUNT = 15;

	// Ready idles high so a port-mode pin never stretches a bus cycle
	localparam logic [IN_COUNT-1:0] IN_IDLE = 15'h2000;

	// Reset values of pad flops
	localparam logic PAD_OUT_RST = 1'h0;
	localparam logic PAD_OE_RST  = 1'h0;

endpackage

// ---- hw/shared_pin_function_select.sv ----
// Top of the shared pin function select block
`timescale 1ns/10ps
`default_nettype none
module shared_pin_function_select (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// Bus mode and bus control settings
	input  wire logic        ext_bus_mode,
	input  wire logic        bus_width_16,
	input  wire logic        upper_addr_sel,
	input  wire logic        clk_out_en,
	input  wire logic        hold_en,
	input  wire logic        wr_strobe_en,
	// Peripheral enables
	input  wire logic        pulse_width_out_ch5_out_en,
	input  wire logic        pulse_gen_trig_en,
	input  wire logic        pulse_gen_out_en,
	input  wire logic        adc_trig_en,
	input  wire logic        serial_mem_en,
	input  wire logic [1:0]  dac_out_en,
	input  wire logic [7:0]  analog_in_en,
	input  wire logic [3:0]  ext_irq_en,
	input  wire logic [5:0]  compare_out_en,
	input  wire logic [3:0]  capture_en,
	input  wire logic        prescaler_clk_out_en,
	input  wire logic        uart_en,
	input  wire logic        ext_serial_en,
	input  wire logic        ext_serial_sel_b,
	input  wire logic [2:0]  od_port9,
	input  wire logic [5:0]  od_porta,
	// Port data and direction registers
	input  wire logic [2:0]  port4_data,
	input  wire logic [2:0]  port4_dir,
	input  wire logic [6:0]  port5_data,
	input  wire logic [6:0]  port5_dir,
	input  wire logic [7:0]  port6_data,
	input  wire logic [7:0]  port6_dir,
	input  wire logic [6:0]  port7_data,
	input  wire logic [6:0]  port7_dir,
	input  wire logic [7:0]  port8_data,
	input  wire logic [7:0]  port8_dir,
	input  wire logic [6:0]  port9_data,
	input  wire logic [6:0]  port9_dir,
	input  wire logic [5:0]  porta_data,
	input  wire logic [5:0]  porta_dir,
	// Pads
	input  wire logic [2:0]  pad4_in,
	output wire logic [2:0]  pad4_out,
	output wire logic [2:0]  pad4_oe,
	input  wire logic [6:0]  pad5_in,
	output wire logic [6:0]  pad5_out,
	output wire logic [6:0]  pad5_oe,
	input  wire logic [7:0]  pad6_in,
	output wire logic [7:0]  pad6_out,
	output wire logic [7:0]  pad6_oe,
	input  wire logic [6:0]  pad7_in,
	output wire logic [6:0]  pad7_out,
	output wire logic [6:0]  pad7_oe,
	input  wire logic [7:0]  pad8_in,
	output wire logic [7:0]  pad8_out,
	output wire logic [7:0]  pad8_oe,
	input  wire logic [6:0]  pad9_in,
	output wire logic [6:0]  pad9_out,
	output wire logic [6:0]  pad9_oe,
	input  wire logic [5:0]  pada_in,
	output wire logic [5:0]  pada_out,
	output wire logic [5:0]  pada_oe,
	// Peripheral outputs toward the pins
	input  wire logic [2:0]  ext_addr_hi,
	input  wire logic        pulse_width_out_ch5,
	input  wire logic        pulse_gen_out,
	input  wire logic        serial_mem_data_out,
	input  wire logic        serial_mem_clock_out,
	input  wire logic        serial_mem_select_out,
	input  wire logic [5:0]  compare_out,
	input  wire logic        prescaler_clock_out,
	input  wire logic        uart_tx_data,
	input  wire logic        uart_serial_clock,
	input  wire logic        ext_serial_tx,
	input  wire logic        ext_serial_clk,
	input  wire logic        bus_clock,
	input  wire logic        bus_hold_ack,
	input  wire logic        upper_byte_write_strobe,
	input  wire logic        lower_byte_write_strobe,
	input  wire logic        read_strobe,
	// Pin levels toward the peripherals
	output wire logic        pulse_gen_trigger_in,
	output wire logic        adc_trigger_in,
	output wire logic        serial_mem_data_in,
	output wire logic [3:0]  ext_irq_in,
	output wire logic [3:0]  capture_edge,
	output wire logic        uart_rx_data,
	output wire logic        ext_serial_rx,
	output wire logic        bus_ready,
	output wire logic        bus_hold_request
);
	localparam int N = pin_mux_pkg::PIN_COUNT;
	localparam int M = pin_mux_pkg::IN_COUNT;

	logic [2:0]   drv4;
	logic [2:0]   val4;
	logic [2:0]   flt4;
	logic [6:0]   drv5;
	logic [6:0]   val5;
	logic [6:0]   flt5;
	logic [7:0]   drv6;
	logic [7:0]   val6;
	logic [7:0]   flt6;
	logic [6:0]   drv7;
	logic [6:0]   val7;
	logic [6:0]   flt7;
	logic [7:0]   drv8;
	logic [7:0]   val8;
	logic [7:0]   flt8;
	logic [6:0]   drv9;
	logic [6:0]   val9;
	logic [6:0]   flt9;
	logic [5:0]   drva;
	logic [5:0]   vala;
	logic [5:0]   flta;
	logic         addr_mode;
	logic         grp_a;
	logic         grp_b;
	logic [N-1:0] alt_drive;
	logic [N-1:0] alt_val;
	logic [N-1:0] alt_float;
	logic [N-1:0] dir_all;
	logic [N-1:0] data_all;
	logic [N-1:0] od_all;
	logic [N-1:0] pad_out_all;
	logic [N-1:0] pad_oe_all;
	logic [M-1:0] raw;
	logic [M-1:0] in_en;
	logic [M-1:0] sampled;

	// ----------------------------------------------------------------
	// Upper address pins
	// ----------------------------------------------------------------
	always_comb begin
		addr_mode = ext_bus_mode & upper_addr_sel;
		drv4 = {3{addr_mode}};
		val4 = ext_addr_hi;
		flt4 = 3'h0;
		if (!addr_mode) begin
			drv4 = {pulse_gen_out_en, 1'h0, pulse_width_out_ch5_out_en};
			val4 = {pulse_gen_out, 1'h0, pulse_width_out_ch5};
			flt4 = {1'h0, pulse_gen_trig_en, 1'h0};
		end
	end

	// ----------------------------------------------------------------
	// External bus control pins
	// ----------------------------------------------------------------
	always_comb begin
		drv5 = 7'h0;
		val5 = 7'h0;
		flt5 = 7'h0;
		drv5[0] = ext_bus_mode & clk_out_en;
		val5[0] = bus_clock;
		flt5[1] = ext_bus_mode;
		drv5[2] = hold_en;
		val5[2] = bus_hold_ack;
		flt5[3] = hold_en;
		drv5[4] = ext_bus_mode & bus_width_16 & wr_strobe_en;
		val5[4] = upper_byte_write_strobe;
		drv5[5] = ext_bus_mode & wr_strobe_en;
		val5[5] = lower_byte_write_strobe;
		drv5[6] = ext_bus_mode;
		val5[6] = read_strobe;
	end

	// ----------------------------------------------------------------
	// Analog, trigger, serial memory and D/A pins
	// ----------------------------------------------------------------
	always_comb begin
		drv6 = 8'h0;
		val6 = 8'h0;
		flt6 = analog_in_en;
		drv7 = {2'h0, {3{serial_mem_en}}, 2'h0};
		val7 = {2'h0, serial_mem_select_out, serial_mem_clock_out,
			serial_mem_data_out, 2'h0};
		// D/A pins carry an analog level, so the digital driver lets go
		flt7 = {dac_out_en, 3'h0, serial_mem_en, adc_trig_en};
	end

	// ----------------------------------------------------------------
	// Interrupt, compare and capture pins
	// ----------------------------------------------------------------
	always_comb begin
		// Interrupt pins keep their port driver unless compare outputs 0-1 take pins 2-3; software keeps it quiet
		drv8 = {compare_out_en, 2'h0};
		val8 = {compare_out, 2'h0};
		flt8 = 8'h0;
		drv9 = {uart_en, uart_en, 1'h0, prescaler_clk_out_en, 3'h0};
		val9 = {uart_serial_clock, uart_tx_data, 1'h0, prescaler_clock_out, 3'h0};
		flt9 = {2'h0, uart_en, 4'h0};
	end

	// ----------------------------------------------------------------
	// Extended serial pin groups
	// ----------------------------------------------------------------
	always_comb begin
		grp_a = ext_serial_en & ~ext_serial_sel_b;
		grp_b = ext_serial_en & ext_serial_sel_b;
		drva = {grp_b, grp_b, 1'h0, grp_a, grp_a, 1'h0};
		vala = {ext_serial_clk, ext_serial_tx, 1'h0, ext_serial_clk, ext_serial_tx, 1'h0};
		flta = {2'h0, grp_b, 2'h0, grp_a};
	end

	// ----------------------------------------------------------------
	// Flattened pin vectors
	// ----------------------------------------------------------------
	assign alt_drive = {drva, drv9, drv8, drv7, drv6, drv5, drv4};
	assign alt_val   = {vala, val9, val8, val7, val6, val5, val4};
	assign alt_float = {flta, flt9, flt8, flt7, flt6, flt5, flt4};
	assign dir_all   = {porta_dir, port9_dir, port8_dir, port7_dir, port6_dir,
		port5_dir, port4_dir};
	assign data_all  = {porta_data, port9_data, port8_data, port7_data, port6_data,
		port5_data, port4_data};
	// Only port 9 bits four to six and port A have an open-drain choice
	assign od_all    = {od_porta, od_port9, 4'h0, 8'h0, 7'h0, 8'h0, 7'h0, 3'h0};

	genvar gi;
	generate
		for (gi = 0; gi < N; gi++) begin : g_pin
			pin_cell u_cell (
				.mclk       (mclk),
				.rst_n      (rst_n),
				.alt_drive  (alt_drive[gi]),
				.alt_val    (alt_val[gi]),
				.alt_float  (alt_float[gi]),
				.port_dir   (dir_all[gi]),
				.port_data  (data_all[gi]),
				.open_drain (od_all[gi]),
				.pad_out    (pad_out_all[gi]),
				.pad_oe     (pad_oe_all[gi])
			);
		end
	endgenerate

	assign pad4_out = pad_out_all[pin_mux_pkg::P4_BASE +: pin_mux_pkg::P4_WIDTH];
	assign pad4_oe  = pad_oe_all[pin_mux_pkg::P4_BASE +: pin_mux_pkg::P4_WIDTH];
	assign pad5_out = pad_out_all[pin_mux_pkg::P5_BASE +: pin_mux_pkg::P5_WIDTH];
	assign pad5_oe  = pad_oe_all[pin_mux_pkg::P5_BASE +: pin_mux_pkg::P5_WIDTH];
	assign pad6_out = pad_out_all[pin_mux_pkg::P6_BASE +: pin_mux_pkg::P6_WIDTH];
	assign pad6_oe  = pad_oe_all[pin_mux_pkg::P6_BASE +: pin_mux_pkg::P6_WIDTH];
	assign pad7_out = pad_out_all[pin_mux_pkg::P7_BASE +: pin_mux_pkg::P7_WIDTH];
	assign pad7_oe  = pad_oe_all[pin_mux_pkg::P7_BASE +: pin_mux_pkg::P7_WIDTH];
	assign pad8_out = pad_out_all[pin_mux_pkg::P8_BASE +: pin_mux_pkg::P8_WIDTH];
	assign pad8_oe  = pad_oe_all[pin_mux_pkg::P8_BASE +: pin_mux_pkg::P8_WIDTH];
	assign pad9_out = pad_out_all[pin_mux_pkg::P9_BASE +: pin_mux_pkg::P9_WIDTH];
	assign pad9_oe  = pad_oe_all[pin_mux_pkg::P9_BASE +: pin_mux_pkg::P9_WIDTH];
	assign pada_out = pad_out_all[pin_mux_pkg::PA_BASE +: pin_mux_pkg::PA_WIDTH];
	assign pada_oe  = pad_oe_all[pin_mux_pkg::PA_BASE +: pin_mux_pkg::PA_WIDTH];

	// ----------------------------------------------------------------
	// Pin levels toward the peripherals
	// ----------------------------------------------------------------
	always_comb begin
		raw = '0;
		in_en = '0;
		raw[pin_mux_pkg::IN_TRIG] = pad4_in[1];
		in_en[pin_mux_pkg::IN_TRIG] = pulse_gen_trig_en & ~addr_mode;
		raw[pin_mux_pkg::IN_ADC] = pad7_in[0];
		in_en[pin_mux_pkg::IN_ADC] = adc_trig_en;
		raw[pin_mux_pkg::IN_SMEM] = pad7_in[1];
		in_en[pin_mux_pkg::IN_SMEM] = serial_mem_en;
		// The sampled level includes any port output left on the pin
		raw[pin_mux_pkg::IN_IRQ +: 4] = pad8_in[3:0];
		in_en[pin_mux_pkg::IN_IRQ +: 4] = ext_irq_en;
		raw[pin_mux_pkg::IN_CAP +: 4] = pad9_in[3:0];
		in_en[pin_mux_pkg::IN_CAP +: 4] = capture_en;
		raw[pin_mux_pkg::IN_URX] = pad9_in[4];
		in_en[pin_mux_pkg::IN_URX] = uart_en;
		raw[pin_mux_pkg::IN_ERX] = grp_b ? pada_in[3] : pada_in[0];
		in_en[pin_mux_pkg::IN_ERX] = ext_serial_en;
		raw[pin_mux_pkg::IN_RDY] = pad5_in[1];
		in_en[pin_mux_pkg::IN_RDY] = ext_bus_mode;
		raw[pin_mux_pkg::IN_HRQ] = pad5_in[3];
		in_en[pin_mux_pkg::IN_HRQ] = hold_en;
	end

	// One flop stage on every level keeps each output straight from a register
	pin_input_gate u_gate (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.raw     (raw),
		.enable  (in_en),
		.sampled (sampled)
	);

	assign pulse_gen_trigger_in = sampled[pin_mux_pkg::IN_TRIG];
	assign adc_trigger_in       = sampled[pin_mux_pkg::IN_ADC];
	assign serial_mem_data_in   = sampled[pin_mux_pkg::IN_SMEM];
	assign ext_irq_in           = sampled[pin_mux_pkg::IN_IRQ +: 4];
	assign capture_edge         = sampled[pin_mux_pkg::IN_CAP +: 4];
	assign uart_rx_data         = sampled[pin_mux_pkg::IN_URX];
	assign ext_serial_rx        = sampled[pin_mux_pkg::IN_ERX];
	assign bus_ready            = sampled[pin_mux_pkg::IN_RDY];
	assign bus_hold_request     = sampled[pin_mux_pkg::IN_HRQ];
endmodule // shared_pin_function_select
`default_nettype wire

// ---- test/pin_board_model.sv ----
// Board-side model of the shared pins
`timescale 1ns/10ps
`default_nettype none
module pin_board_model #(
	parameter int W = 46
) (
	input  wire logic [W-1:0] drive,
	input  wire logic [W-1:0] oe,
	input  wire logic [W-1:0] board,
	output wire logic [W-1:0] pins
);
	// Released pins show the board level, never a stale chip value
	// Ready comes from here in bus mode, hold request while hold is enabled
	assign pins = (oe & drive) | (~oe & board);
endmodule // pin_board_model
`default_nettype wire

// ---- test/shared_pin_function_select_checker.sv ----
// Concurrent checks on the ports of the shared pin function select block
`timescale 1ns/10ps
`default_nettype none
module shared_pin_function_select_checker (
	input wire logic       mclk, rst_n, ext_bus_mode, bus_width_16, upper_addr_sel, hold_en,
	input wire logic       wr_strobe_en, pulse_width_out_ch5_out_en, pulse_gen_trig_en, uart_en,
	input wire logic       pulse_width_out_ch5, bus_hold_ack, upper_byte_write_strobe,
	input wire logic       pulse_gen_trigger_in, bus_ready, bus_hold_request,
	input wire logic [2:0] ext_addr_hi, od_port9, pad4_in, pad4_out, pad4_oe,
	input wire logic [3:0] ext_irq_en, capture_en, ext_irq_in, capture_edge,
	input wire logic [5:0] compare_out_en, compare_out,
	input wire logic [6:0] pad5_in, pad5_out, pad5_oe, port9_data, port9_dir, pad9_in, pad9_oe,
	input wire logic [7:0] analog_in_en, pad6_oe, pad8_in, pad8_out, pad8_oe
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Sequences
	// ------------------------------------------------------------
	sequence s_addr_mode;
		ext_bus_mode && upper_addr_sel;
	endsequence
	sequence s_ready_follows;
		##1 bus_ready == $past(pad5_in[1]) && !pad5_oe[1];
	endsequence

	// ------------------------------------------------------------
	// Pins and sampled levels, one cycle after the inputs that cause them
	// ------------------------------------------------------------
	a_addr_drive: assert property (s_addr_mode |=>
		pad4_oe == 3'h7 && pad4_out == $past(ext_addr_hi)) else $error("address pins wrong");
	a_pulse_width_out_ch5_out: assert property (!(ext_bus_mode && upper_addr_sel) && pulse_width_out_ch5_out_en |=>
		pad4_oe[0] && pad4_out[0] == $past(pulse_width_out_ch5)) else $error("pulse_width_out_ch5 pin wrong");
	a_trig_sample: assert property (!(ext_bus_mode && upper_addr_sel) && pulse_gen_trig_en |=>
		pulse_gen_trigger_in == $past(pad4_in[1])) else $error("trigger level wrong");
	a_analog_off: assert property (analog_in_en != 8'h00 |=>
		(pad6_oe & $past(analog_in_en)) == 8'h00) else $error("analog pin driven");
	a_irq_sample: assert property (1'b1 |=>
		ext_irq_in == ($past(pad8_in[3:0]) & $past(ext_irq_en))) else $error("irq level wrong");
	a_capture_level: assert property (1'b1 |=>
		capture_edge == ($past(pad9_in[3:0]) & $past(capture_en))) else $error("capture wrong");
	a_compare_drive: assert property (compare_out_en == 6'h3f |=>
		pad8_oe[7:2] == 6'h3f && pad8_out[7:2] == $past(compare_out)) else $error("compare wrong");
	a_bus_ready: assert property (ext_bus_mode |-> s_ready_follows)
		else $error("ready input wrong");
	a_hold_pins: assert property (hold_en |=> pad5_oe[2] && pad5_out[2] == $past(bus_hold_ack) &&
		bus_hold_request == $past(pad5_in[3])) else $error("hold pins wrong");
	a_wr_upper: assert property (ext_bus_mode && bus_width_16 && wr_strobe_en |=>
		pad5_oe[4] && pad5_out[4] == $past(upper_byte_write_strobe)) else $error("upper strobe wrong");
	a_od_release: assert property (!uart_en && od_port9[0] && port9_dir[4] && port9_data[4] |=>
		!pad9_oe[4]) else $error("open drain high still driven");
endmodule // shared_pin_function_select_checker

bind shared_pin_function_select shared_pin_function_select_checker chk_u (.*);
`default_nettype wire

// ---- test/test_shared_pin_function_select.sv ----
// Self-checking bench for the shared pin function select block
`timescale 1ns/10ps
`default_nettype none
module test_shared_pin_function_select;
	logic        mclk, rst_n, ext_bus_mode, bus_width_16, upper_addr_sel, clk_out_en, hold_en;
	logic        wr_strobe_en, pulse_width_out_ch5_out_en, pulse_gen_trig_en, pulse_gen_out_en, adc_trig_en;
	logic        serial_mem_en, prescaler_clk_out_en, uart_en, ext_serial_en, ext_serial_sel_b;
	logic        pulse_width_out_ch5, pulse_gen_out, serial_mem_data_out, serial_mem_clock_out;
	logic        serial_mem_select_out, prescaler_clock_out, uart_tx_data, uart_serial_clock;
	logic        ext_serial_tx, ext_serial_clk, bus_clock, bus_hold_ack, read_strobe;
	logic        upper_byte_write_strobe, lower_byte_write_strobe;
	logic [1:0]  dac_out_en;
	logic [2:0]  od_port9, port4_data, port4_dir, ext_addr_hi;
	logic [3:0]  ext_irq_en, capture_en;
	logic [5:0]  compare_out_en, compare_out, od_porta, porta_data, porta_dir;
	logic [6:0]  port5_data, port5_dir, port7_data, port7_dir, port9_data, port9_dir;
	logic [7:0]  analog_in_en, port6_data, port6_dir, port8_data, port8_dir;
	logic [45:0] board;
	wire  [45:0] pins;
	wire  [2:0]  pad4_in, pad4_out, pad4_oe;
	wire  [6:0]  pad5_in, pad5_out, pad5_oe, pad7_in, pad7_out, pad7_oe, pad9_in, pad9_out, pad9_oe;
	wire  [7:0]  pad6_in, pad6_out, pad6_oe, pad8_in, pad8_out, pad8_oe;
	wire  [5:0]  pada_in, pada_out, pada_oe;
	wire  [3:0]  ext_irq_in, capture_edge;
	wire         pulse_gen_trigger_in, adc_trigger_in, serial_mem_data_in, uart_rx_data;
	wire         ext_serial_rx, bus_ready, bus_hold_request;
	int          n_mismatch = 0;
	int          total_checks = 0;

	// ------------------------------------------------------------
	// Design, board and clock
	// ------------------------------------------------------------
	shared_pin_function_select dut_u (.*);
	pin_board_model board_u (
		.drive ({pada_out, pad9_out, pad8_out, pad7_out, pad6_out, pad5_out, pad4_out}),
		.oe    ({pada_oe, pad9_oe, pad8_oe, pad7_oe, pad6_oe, pad5_oe, pad4_oe}),
		.board (board),
		.pins  (pins)
	);
	assign {pada_in, pad9_in, pad8_in, pad7_in, pad6_in, pad5_in, pad4_in} = pins;
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] seen);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Outputs are flops: one edge later they hold the result, settled 1 ns on
	task automatic tick();
		@(posedge mclk);
		#1;
	endtask
	task automatic clear();
		{ext_bus_mode, bus_width_16, upper_addr_sel, clk_out_en, hold_en, wr_strobe_en,
			pulse_width_out_ch5_out_en, pulse_gen_trig_en, pulse_gen_out_en, adc_trig_en, serial_mem_en,
			prescaler_clk_out_en, uart_en, ext_serial_en, ext_serial_sel_b, pulse_width_out_ch5,
			pulse_gen_out, serial_mem_data_out, serial_mem_clock_out, serial_mem_select_out,
			prescaler_clock_out, uart_tx_data, uart_serial_clock, ext_serial_tx, ext_serial_clk,
			bus_clock, bus_hold_ack, read_strobe, upper_byte_write_strobe, lower_byte_write_strobe,
			dac_out_en, od_port9, port4_data, port4_dir, ext_addr_hi, ext_irq_en, capture_en,
			compare_out_en, compare_out, od_porta, porta_data, porta_dir, port5_data, port5_dir,
			port7_data, port7_dir, port9_data, port9_dir, analog_in_en, port6_data, port6_dir,
			port8_data, port8_dir} = '0;
		board = '0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_upper();
		clear();
		{ext_bus_mode, upper_addr_sel, pulse_width_out_ch5_out_en, pulse_gen_out_en} = 4'hf;
		ext_addr_hi = 3'h5;
		tick();
		check("addr_pins", 8'h75, {1'b0, pad4_oe, 1'b0, pad4_out});
		upper_addr_sel = 1'b0;
		{pulse_width_out_ch5, pulse_gen_out, pulse_gen_trig_en, board[1]} = 4'hf;
		tick();
		check("alt_oe", 8'h05, pad4_oe);
		check("alt_out", 8'h05, pad4_out & 3'h5);
		// The pin was still driven as address at the first edge
		tick();
		check("trig_on", 8'h01, pulse_gen_trigger_in);
		{upper_addr_sel, ext_addr_hi} = 4'hf;
		tick();
		tick();
		check("trig_addr", 8'h00, pulse_gen_trigger_in);
	endtask
	task automatic t_port7();
		clear();
		{port7_dir, port7_data} = 14'h3fd5;
		{adc_trig_en, serial_mem_en, dac_out_en} = 4'hf;
		{serial_mem_select_out, serial_mem_clock_out, serial_mem_data_out} = 3'h5;
		board[19:18] = 2'h3;
		tick();
		check("p7_oe", 8'h1c, pad7_oe);
		check("smem_out", 8'h05, pad7_out[4:2]);
		check("p7_in", 8'h03, {serial_mem_data_in, adc_trigger_in});
		{adc_trig_en, serial_mem_en, dac_out_en} = 4'h0;
		tick();
		check("p7_port", 8'h7f, pad7_oe);
		check("p7_data", 8'h55, pad7_out);
		check("p7_idle", 8'h00, {serial_mem_data_in, adc_trigger_in});
	endtask
	task automatic t_analog();
		clear();
		{port6_dir, analog_in_en} = 16'hff0f;
		port6_data = 8'h5a;
		tick();
		check("an_low", 8'hf0, pad6_oe);
		check("an_data", 8'h5a, pad6_out);
		analog_in_en = 8'hf0;
		tick();
		check("an_high", 8'h0f, pad6_oe);
	endtask
	task automatic t_irq_cap();
		clear();
		// Compare outputs stay off on the interrupt pins
		port8_dir = 8'h0f;
		port8_data = 8'h0a;
		ext_irq_en = 4'hf;
		compare_out_en = 6'h00;
		{capture_en, prescaler_clk_out_en, prescaler_clock_out} = 6'h3f;
		board[36:33] = 4'h6;
		tick();
		tick();
		check("irq_oe", 8'h0f, pad8_oe[3:0]);
		check("irq_in", 8'h0a, ext_irq_in);
		check("cap_in", 8'h0e, capture_edge);
		check("presc", 8'h03, {pad9_oe[3], pad9_out[3]});
		ext_irq_en = 4'h3;
		tick();
		check("irq_part", 8'h02, ext_irq_in);
	endtask
	task automatic t_compare();
		clear();
		{compare_out_en, compare_out} = 12'hfed;
		tick();
		check("cmp_oe", 8'hfc, pad8_oe & 8'hfc);
		check("cmp_out", 8'hb4, pad8_out & 8'hfc);
		compare_out_en = 6'h01;
		tick();
		check("cmp_one", 8'h04, pad8_oe);
	endtask
	task automatic t_serial();
		clear();
		{uart_en, uart_tx_data, uart_serial_clock, od_port9} = 6'h2a;
		board[37] = 1'b1;
		tick();
		check("uart_pins", 8'h1a, {pad9_oe[6:4], pad9_out[6:5]});
		check("uart_rx", 8'h01, uart_rx_data);
		{uart_en, od_port9, port9_dir[4], port9_data[4]} = 6'h07;
		tick();
		check("od_high", 8'h00, pad9_oe[4]);
		port9_data[4] = 1'b0;
		tick();
		check("od_low", 8'h01, {pad9_out[4], pad9_oe[4]});
		board[45:40] = 6'h01;
		for (int g = 0; g < 2; g++) begin
			{ext_serial_en, ext_serial_sel_b, ext_serial_tx, ext_serial_clk} = {1'b1, g[0], 2'h3};
			tick();
			check("es_oe", (g == 0) ? 8'h06 : 8'h30, pada_oe);
			check("es_out", (g == 0) ? 8'h06 : 8'h30, pada_out);
			check("es_rx", {7'h00, ~g[0]}, ext_serial_rx);
		end
		ext_serial_en = 1'b0;
		tick();
		check("es_off", 8'h00, pada_oe);
	endtask
	task automatic t_bus();
		logic [7:0] exp5;
		clear();
		{bus_clock, bus_hold_ack, upper_byte_write_strobe, lower_byte_write_strobe} = 4'hf;
		read_strobe = 1'b1;
		board[6:3] = 4'h8;
		// Single chip, 16-bit bus, then 8-bit bus
		for (int m = 0; m < 3; m++) begin
			{ext_bus_mode, clk_out_en, hold_en, wr_strobe_en} = (m == 0) ? 4'h0 : 4'hf;
			bus_width_16 = (m == 1);
			exp5 = (m == 0) ? 8'h00 : ((m == 1) ? 8'h75 : 8'h65);
			tick();
			check("bus_oe", exp5, pad5_oe);
			check("bus_out", exp5, pad5_out);
			check("rdy_hrq", (m == 0) ? 8'h02 : 8'h01, {bus_ready, bus_hold_request});
		end
	endtask

	initial begin
		clear();
		rst_n = 1'b0;
		repeat (8) @(posedge mclk);
		#1;
		check("rst_ready", 8'h01, bus_ready);
		check("rst_oe", 8'h00, pad5_oe);
		rst_n = 1'b1;
		t_upper();
		t_port7();
		t_analog();
		t_irq_cap();
		t_compare();
		t_serial();
		t_bus();
		results();
	end
	// About 31 cycles are needed; over fifteen times that marks a hang
	initial begin
		#2500;
		n_mismatch++;
		results();
	end
endmodule // test_shared_pin_function_select
`default_nettype wire
